// file: fixed_freq_pwm_protect_timing.sv
`timescale 1ns/1ns
`include "pwm_protect_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Oscillator at 100 kHz, jittered plus or minus 4 percent over 4 ms.
// - On time never exceeds three quarters of the switching period.
// - Jitter runs only once soft start has completed.
// - Latch set each oscillator pulse until auto restart; cleared by feedback, soft-start, limit.
// - Cleared latch forces gate off at once, combinationally.
// - Gate held low while supply is below lockout threshold.
// - Peak limit comparator trip clears latch immediately, ending the pulse.
// - Sense ignored after turn-on: 220 ns normal, 180 ns burst.
// - Burst limit comparator enabled only while in active burst mode.
// - Burst and auto restart entry need condition held 20 ms.
// - With capacitor fitted, overload stays blocked; charge and count start.
// - Upper threshold: count up, stop charging, start discharging.
// - Discharge until lower threshold, then resume charging.
// - Repeat until 256 counts, then raise counter completion.
// - Blanking expired and completion: 30 ms spike blank, then restart.
// - Steeper current slope moves limit turn-off earlier, both thresholds.
// - Soft-start limit rises in 32 steps of 300 us, then off.
// - Feedback above burst exit level leaves burst, restoring full limit.
module fixed_freq_pwm_protect_timing
  import pwm_protect_pkg::*;
(
  // Clock and reset (reset is the lockout)
  input  wire logic clk,
  input  wire logic rst,
  // Comparator inputs
  input  wire logic feedback_trip,
  input  wire logic soft_start_trip,
  input  wire logic peak_limit_comparator,
  input  wire logic peak_limit_early,
  input  wire logic burst_limit_comparator,
  input  wire logic burst_limit_early,
  input  wire logic sense_steep,
  // Mode conditions
  input  wire logic burst_entry_cond,
  input  wire logic burst_exit_cond,
  input  wire logic overload_cond,
  input  wire logic fault_cond,
  input  wire logic lockout_below,
  // Extension capacitor
  input  wire logic extension_fitted,
  input  wire logic extension_upper_comparator,
  input  wire logic extension_lower_comparator,
  // Gate and status
  output logic      gate_drive,
  output logic      switching_latch,
  output logic      osc_pulse,
  output logic      burst_limit_gate,
  output logic      sense_blank,
  output logic      soft_start_active,
  output logic [4:0] soft_start_step,
  output logic      extension_charge_switch,
  output logic      extension_discharge_switch,
  output logic      extension_done,
  output logic      overload_release_gate,
  output logic      burst_mode,
  output logic      auto_restart
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int OSC_NOM   = `OSC_NOM_CYC;
  localparam int JIT_SPAN  = `JIT_SPAN_CYC;
  localparam int JIT_STEP  = `JIT_STEP_CYC;
  localparam int LEB_NORM  = `LEB_NORM_CYC;
  localparam int LEB_BURST = `LEB_BURST_CYC;

  typedef struct packed {
    logic [10:0]   osc_cnt;
    logic [10:0]   period;
    logic [6:0]    jit_ofs;
    logic          jit_up;
    logic [15:0]   jit_div;
    logic          latch;
    logic [4:0]    leb_cnt;
    logic [15:0]   soft_div;
    logic [4:0]    soft_step;
    logic          soft_on;
    logic          burst;
    logic [21:0]   burst_tmr;
    ovl_state_type ovl;
    logic [21:0]   ovl_tmr;
    ext_state_type ext;
    logic [8:0]    ext_cnt;
    logic          restart;
  } state_type;

  state_type s_q;
  state_type s_d;

  // Shared reload test for the long timers
  function automatic logic reached(input logic [21:0] cnt, input int lim);
    reached = (int'(cnt) >= lim - 1);
  endfunction : reached

  // Shared increment for the long timers
  function automatic logic [21:0] tick(input logic [21:0] cnt);
    tick = cnt + 22'h00_0001;
  endfunction : tick

  // Blank length follows the mode at turn-on
  function automatic logic [4:0] leb_len(input logic in_burst);
    leb_len = in_burst ? 5'(LEB_BURST) : 5'(LEB_NORM);
  endfunction : leb_len

  ////////////////////////////////////////////////////////////////////////////
  logic on_limit;
  logic pulse;
  logic blanked;
  logic cur_trip;
  logic burst_trip;

  always_comb begin
    s_d      = s_q;
    pulse    = (s_q.osc_cnt == 11'h000);
    on_limit = (int'(s_q.osc_cnt) >=
                (int'(s_q.period) * `DUTY_MAX_NUM) / `DUTY_MAX_DEN);
    blanked  = (s_q.leb_cnt != 5'h00);
    // Early comparator outputs used on steep slopes to hide turn-off delay
    cur_trip = sense_steep ? peak_limit_early
                           : peak_limit_comparator;
    burst_trip = s_q.burst &&
                 (sense_steep ? burst_limit_early
                              : burst_limit_comparator);

    // Oscillator with triangular jitter sweep
    if (int'(s_q.osc_cnt) >= int'(s_q.period) - 1) begin
      s_d.osc_cnt = 11'h000;
    end else begin
      s_d.osc_cnt = s_q.osc_cnt + 11'h001;
    end
    if (!s_q.soft_on) begin
      if (int'(s_q.jit_div) >= JIT_STEP - 1) begin
        s_d.jit_div = 16'h0000;
        if (s_q.jit_up) begin
          s_d.jit_ofs = s_q.jit_ofs + 7'h01;
          s_d.jit_up  = (int'(s_q.jit_ofs) < 2 * JIT_SPAN - 1);
        end else begin
          s_d.jit_ofs = s_q.jit_ofs - 7'h01;
          s_d.jit_up  = (s_q.jit_ofs == 7'h01);
        end
      end else begin
        s_d.jit_div = s_q.jit_div + 16'h0001;
      end
    end
    if (pulse) begin
      s_d.period = 11'(OSC_NOM - JIT_SPAN + int'(s_q.jit_ofs));
    end

    // Switching latch: set wins only at cycle start, resets dominate after
    if (pulse && !s_q.restart) begin
      s_d.latch   = 1'b1;
      s_d.leb_cnt = leb_len(s_q.burst);
    end else begin
      if (blanked) begin
        s_d.leb_cnt = s_q.leb_cnt - 5'h01;
      end
      if (on_limit || feedback_trip || soft_start_trip) begin
        s_d.latch = 1'b0;
      end
      if (!blanked && (cur_trip || burst_trip)) begin
        s_d.latch = 1'b0;
      end
    end

    // Soft start: 32 steps then switched off
    if (s_q.soft_on) begin
      if (int'(s_q.soft_div) >= `SOFT_STEP_CYC - 1) begin
        s_d.soft_div = 16'h0000;
        if (int'(s_q.soft_step) == `SOFT_STEPS - 1) begin
          s_d.soft_on = 1'b0;
        end else begin
          s_d.soft_step = s_q.soft_step + 5'h01;
        end
      end else begin
        s_d.soft_div = s_q.soft_div + 16'h0001;
      end
    end

    // Burst entry after 20 ms, exit on feedback rise
    if (s_q.burst) begin
      s_d.burst_tmr = '0;
      if (burst_exit_cond) begin
        s_d.burst = 1'b0;
      end
    end else if (!burst_entry_cond) begin
      s_d.burst_tmr = '0;
    end else if (reached(s_q.burst_tmr, `BLANK_CYC)) begin
      s_d.burst     = 1'b1;
      s_d.burst_tmr = '0;
    end else begin
      // Timer only runs while entry holds, so a brief dip restarts it
      s_d.burst_tmr = tick(s_q.burst_tmr);
    end

    // Overload blanking, extension and spike blank
    unique case (s_q.ovl)
      ovl_idle: begin
        s_d.ovl_tmr = '0;
        if (overload_cond || fault_cond) begin
          s_d.ovl = ovl_blank;
        end
      end
      ovl_blank: begin
        s_d.ovl_tmr = tick(s_q.ovl_tmr);
        if (!overload_cond && !fault_cond) begin
          s_d.ovl = ovl_idle;
        end else if (reached(s_q.ovl_tmr, `BLANK_CYC)) begin
          s_d.ovl_tmr = '0;
          if (extension_fitted && !fault_cond) begin
            s_d.ovl = ovl_extend;
            s_d.ext = ext_charge;
          end else begin
            s_d.restart = 1'b1;
            s_d.ovl     = ovl_idle;
          end
        end
      end
      ovl_extend: begin
        if (!overload_cond) begin
          s_d.ovl     = ovl_idle;
          s_d.ext     = ext_idle;
          s_d.ext_cnt = '0;
        end else if (s_q.ext == ext_done) begin
          s_d.ovl = ovl_spike;
        end
      end
      ovl_spike: begin
        s_d.ovl_tmr = tick(s_q.ovl_tmr);
        // Overload gone before restart: drop back and forget the count
        if (!overload_cond) begin
          s_d.ovl     = ovl_idle;
          s_d.ext     = ext_idle;
          s_d.ext_cnt = '0;
        end else if (reached(s_q.ovl_tmr, `SPIKE_CYC)) begin
          s_d.restart = 1'b1;
          s_d.ovl     = ovl_idle;
          s_d.ext     = ext_idle;
          s_d.ext_cnt = '0;
        end
      end
    endcase

    // Capacitor charge/discharge cycling
    if (s_q.ovl == ovl_extend && overload_cond) begin
      unique case (s_q.ext)
        ext_idle: begin
          s_d.ext = ext_idle;
        end
        ext_charge: begin
          if (extension_upper_comparator) begin
            s_d.ext_cnt = s_q.ext_cnt + 9'h001;
            s_d.ext     = (int'(s_q.ext_cnt) == `EXT_COUNT_DONE - 1)
                          ? ext_done : ext_dis;
          end
        end
        ext_dis: begin
          if (extension_lower_comparator) begin
            s_d.ext = ext_charge;
          end
        end
        ext_done: begin
          s_d.ext = ext_done;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lockout acts as reset; counters restart from zero except the jitter offset, which restarts at mid-span
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q           <= '0;
      s_q.period    <= 11'(OSC_NOM);
      s_q.jit_ofs   <= 7'(JIT_SPAN);
      s_q.jit_up    <= 1'b1;
      s_q.soft_on   <= 1'b1;
      s_q.ovl       <= ovl_idle;
      s_q.ext       <= ext_idle;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trips seen outside the blank act before the latch register clears
  function automatic logic cur_trip_now();
    cur_trip_now = (s_q.leb_cnt == 5'h00) &&
                   (cur_trip || burst_trip || feedback_trip
                    || soft_start_trip || on_limit);
  endfunction : cur_trip_now

  // Gate is combinational so a cleared latch cuts it in the same cycle
  logic gate_allow;

  always_comb begin
    gate_allow = s_q.latch;
    if (rst || lockout_below) begin
      gate_allow = 1'b0;
    end
    if (cur_trip_now()) begin
      gate_allow = 1'b0;
    end
    // Restart is sticky, so only a lockout reset lets switching resume
    if (s_q.restart) begin
      gate_allow = 1'b0;
    end
  end

  assign gate_drive = gate_allow;

  assign switching_latch            = s_q.latch;
  assign osc_pulse                  = pulse;
  assign burst_limit_gate           = s_q.burst;
  assign sense_blank                = blanked;
  assign soft_start_active          = s_q.soft_on;
  assign soft_start_step            = s_q.soft_step;
  assign extension_charge_switch    = (s_q.ext == ext_charge);
  assign extension_discharge_switch = (s_q.ext == ext_dis);
  assign extension_done             = (s_q.ext == ext_done);
  assign overload_release_gate      = (s_q.ovl == ovl_spike);
  assign burst_mode                 = s_q.burst;
  assign auto_restart               = s_q.restart;

endmodule : fixed_freq_pwm_protect_timing

// file: pwm_protect_cfg.svh
`ifndef PWM_PROTECT_CFG_SVH
`define PWM_PROTECT_CFG_SVH

// Clock and time units
`define CLK_MHZ            100
`define OSC_NOM_KHZ        100
`define JITTER_PCT         4
`define JITTER_PERIOD_US   4000
`define DUTY_MAX_NUM       3
`define DUTY_MAX_DEN       4
`define LEB_NORMAL_NS      220
`define LEB_BURST_NS       180
`define BLANK_BASIC_US     20000
`define SPIKE_BLANK_US     30000
`define SOFT_STEP_US       300
`define SOFT_STEPS         32
`define EXT_COUNT_DONE     256

// Derived cycle counts
`define OSC_NOM_CYC   ((`CLK_MHZ * 1000) / `OSC_NOM_KHZ)
`define JIT_SPAN_CYC  ((`OSC_NOM_CYC * `JITTER_PCT) / 100)
`define JIT_STEP_CYC  ((`JITTER_PERIOD_US * `CLK_MHZ) / (4 * `JIT_SPAN_CYC))
`define LEB_NORM_CYC  ((`LEB_NORMAL_NS * `CLK_MHZ + 999) / 1000)
`define LEB_BURST_CYC ((`LEB_BURST_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_CYC     (`BLANK_BASIC_US * `CLK_MHZ)
`define SPIKE_CYC     (`SPIKE_BLANK_US * `CLK_MHZ)
`define SOFT_STEP_CYC (`SOFT_STEP_US * `CLK_MHZ)

`endif

// file: pwm_protect_pkg.sv
package pwm_protect_pkg;

  typedef enum logic [1:0] {
    ext_idle   = 2'b00,
    ext_charge = 2'b01,
    ext_dis    = 2'b10,
    ext_done   = 2'b11
  } ext_state_type;

  typedef enum logic [1:0] {
    ovl_idle   = 2'b00,
    ovl_blank  = 2'b01,
    ovl_extend = 2'b10,
    ovl_spike  = 2'b11
  } ovl_state_type;

endpackage : pwm_protect_pkg

// file: pwm_switch_model.sv
`timescale 1ns/1ns
module pwm_switch_model (
  // Clock
  input  wire logic       clk,
  // Switch side
  input  wire logic       gate_drive,
  input  wire logic [9:0] trip_after,
  output logic            peak_limit_comparator
);
  logic [9:0] on_q;
  // Sense ramps with on time; one cycle of lag breaks the gate loop
  always_ff @(posedge clk) begin
    on_q <= gate_drive ? on_q + 10'h001 : 10'h000;
    peak_limit_comparator <= gate_drive && (trip_after != 10'h000)
                             && (on_q + 10'h001 >= trip_after);
  end
endmodule : pwm_switch_model

// file: pwm_protect_checker.sv
`timescale 1ns/1ns
module pwm_protect_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched signals
  input wire logic       peak_limit_comparator,
  input wire logic       burst_limit_comparator,
  input wire logic       auto_restart,
  input wire logic       sense_steep,
  input wire logic       lockout_below,
  input wire logic       feedback_trip,
  input wire logic       soft_start_trip,
  input wire logic       gate_drive,
  input wire logic       switching_latch,
  input wire logic       osc_pulse,
  input wire logic       burst_limit_gate,
  input wire logic       burst_mode,
  input wire logic       sense_blank,
  input wire logic       soft_start_active,
  input wire logic [4:0] soft_start_step
);
  logic [9:0] on_q;
  logic [9:0] per_q;
  always_ff @(posedge clk) begin
    on_q  <= (rst || !switching_latch) ? 10'h000 : on_q + 10'h001;
    per_q <= (rst || osc_pulse) ? 10'h000 : per_q + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_gate; !switching_latch |-> !gate_drive; endproperty
  a_gate: assert property (p_gate) else $error("gate on, latch clear");
  property p_lock; lockout_below |-> !gate_drive; endproperty
  a_lock: assert property (p_lock) else $error("gate on in lockout");
  property p_set; osc_pulse && !feedback_trip && !soft_start_trip
    && !lockout_below && !sense_steep && !peak_limit_comparator
    && !auto_restart
    |=> switching_latch; endproperty
  a_set: assert property (p_set) else $error("latch not set");
  property p_blank; $rose(switching_latch) && !burst_mode
    |-> sense_blank ##21 sense_blank ##1 !sense_blank; endproperty
  a_blank: assert property (p_blank) else $error("blank length");
  property p_peak; !sense_blank && peak_limit_comparator && !sense_steep
    |-> !gate_drive; endproperty
  a_peak: assert property (p_peak) else $error("peak trip missed");
  // Latch may stand 750 cycles; jittered periods allow up to 780
  property p_duty; on_q <= (soft_start_active ? 10'h2ee : 10'h30c);
  endproperty
  a_duty: assert property (p_duty) else $error("on time too long");
  property p_per; osc_pulse && !$past(osc_pulse) && soft_start_active
    |-> per_q == 10'h3e7; endproperty
  a_per: assert property (p_per) else $error("period wrong");
  property p_burst; burst_limit_gate && !sense_blank && burst_limit_comparator
    && !sense_steep |-> !gate_drive; endproperty
  a_burst: assert property (p_burst) else $error("burst gate");
  property p_step; $changed(soft_start_step)
    |-> soft_start_step == $past(soft_start_step) + 5'h01; endproperty
  a_step: assert property (p_step) else $error("step skipped");
endmodule : pwm_protect_checker
bind fixed_freq_pwm_protect_timing pwm_protect_checker i_pwm_protect_checker (
  .clk, .rst, .peak_limit_comparator, .burst_limit_comparator,
  .auto_restart, .sense_steep, .lockout_below,
  .feedback_trip, .soft_start_trip, .gate_drive, .switching_latch,
  .osc_pulse, .burst_limit_gate, .burst_mode, .sense_blank,
  .soft_start_active, .soft_start_step);

// file: fixed_freq_pwm_protect_timing_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fixed_freq_pwm_protect_timing_tb_top;
  logic clk = 1'b0, rst = 1'b1, feedback_trip = 1'b0, soft_start_trip = 1'b0;
  logic peak_limit_early = 1'b0, burst_limit_comparator = 1'b0;
  logic burst_limit_early = 1'b0, sense_steep = 1'b0, burst_entry_cond = 1'b0;
  logic burst_exit_cond = 1'b0, overload_cond = 1'b0, fault_cond = 1'b0;
  logic lockout_below = 1'b0, extension_fitted = 1'b0;
  logic extension_upper_comparator = 1'b0, extension_lower_comparator = 1'b0;
  logic peak_limit_comparator, gate_drive, switching_latch, osc_pulse;
  logic burst_limit_gate, sense_blank, soft_start_active, extension_done;
  logic extension_charge_switch, extension_discharge_switch;
  logic overload_release_gate, burst_mode, auto_restart;
  logic [4:0] soft_start_step;
  logic [9:0] trip_after = 10'h000;
  int err_count = 0, samples_checked = 0, n = 0;
  fixed_freq_pwm_protect_timing i_fixed_freq_pwm_protect_timing (.clk, .rst,
    .feedback_trip, .soft_start_trip, .peak_limit_comparator,
    .peak_limit_early, .burst_limit_comparator, .burst_limit_early,
    .sense_steep, .burst_entry_cond, .burst_exit_cond, .overload_cond,
    .fault_cond, .lockout_below, .extension_fitted,
    .extension_upper_comparator, .extension_lower_comparator, .gate_drive,
    .switching_latch, .osc_pulse, .burst_limit_gate, .sense_blank,
    .soft_start_active, .soft_start_step, .extension_charge_switch,
    .extension_discharge_switch, .extension_done, .overload_release_gate,
    .burst_mode, .auto_restart);
  pwm_switch_model i_pwm_switch_model (.clk, .gate_drive, .trip_after,
    .peak_limit_comparator);
  ////////////////////////////////////////
  initial forever #5 clk = ~clk;
  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic sync_pulse;
    @(negedge clk);
    for (int i = 0; i < 2000 && osc_pulse !== 1'b1; i++) @(negedge clk);
  endtask : sync_pulse
  // Counts gate on cycles over one whole nominal period
  task automatic gate_cycles;
    n = 0;
    sync_pulse;
    repeat (1000) begin
      @(negedge clk);
      if (gate_drive === 1'b1) n++;
    end
  endtask : gate_cycles
  task automatic t_trip(input bit fb);
    sync_pulse;
    repeat (100) @(negedge clk);
    @(posedge clk) {feedback_trip, soft_start_trip} <= {fb, !fb};
    #1 `CHK(gate_drive, 1'b0)
    @(posedge clk) {feedback_trip, soft_start_trip} <= 2'b00;
    #1 `CHK(switching_latch, 1'b0)
  endtask : t_trip
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) `CHK(gate_drive, 1'b0)
    `CHK(soft_start_active, 1'b1)
    @(posedge clk) rst <= 1'b0;
    n = 0;
    while (soft_start_step === 5'h00 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= 29990 && n <= 30010, 1'b1)
    sync_pulse;
    @(negedge clk) `CHK(switching_latch, 1'b1)
    for (n = 1; osc_pulse !== 1'b1 && n < 2000; n++) @(negedge clk);
    `CHK(n, 1000)
    // Burst inputs raised out of burst mode must not shorten the pulse
    @(posedge clk) {burst_limit_comparator, burst_limit_early} <= 2'b11;
    gate_cycles;
    `CHK(n >= 745 && n <= 750, 1'b1)
    `CHK({burst_limit_gate, burst_mode}, 2'b00)
    @(posedge clk) {burst_limit_comparator, burst_limit_early} <= 2'b00;
    trip_after <= 10'h005;
    gate_cycles;
    `CHK(n, 22)
    @(posedge clk) trip_after <= 10'h000;
    {sense_steep, peak_limit_early} <= 2'b11;
    gate_cycles;
    `CHK(n, 22)
    @(posedge clk) {sense_steep, peak_limit_early} <= 2'b00;
    t_trip(1'b1);
    t_trip(1'b0);
    @(posedge clk) lockout_below <= 1'b1;
    gate_cycles;
    `CHK(n, 0)
    @(posedge clk) {lockout_below, extension_fitted, overload_cond} <= 3'b011;
    repeat (500) @(negedge clk);
    `CHK({extension_charge_switch, extension_discharge_switch,
          overload_release_gate, auto_restart}, 4'h0)
    @(posedge clk) {overload_cond, fault_cond} <= 2'b01;
    repeat (500) @(negedge clk);
    `CHK({extension_done, auto_restart}, 2'h0)
    stop_test;
  end
  initial begin
    #1_000_000;
    err_count++;
    stop_test;
  end
endmodule : fixed_freq_pwm_protect_timing_tb_top
